/* gpio_pad_model.sv */
// partner model: outside circuitry on the 32 pads
`timescale 1ns/1ps
module gpio_pad_model (
  input  wire logic [31:0] i_ext_en,
  input  wire logic [31:0] i_ext_val,
  input  wire logic [31:0] i_oe,
  input  wire logic [31:0] i_out,
  input  wire logic        i_clock,
  output logic      [31:0] o_pad
);
  // undriven pads wander every cycle so no check can lean on a settled unknown
  logic [31:0] float_r = 32'h5555_5555;
  always_ff @(posedge i_clock) float_r <= ~float_r;
  // the bench holds quiet levels three cycles and parks pins before sensing
  assign o_pad = (i_oe & i_out) | (~i_oe & ((i_ext_en & i_ext_val) | (~i_ext_en & float_r)));
endmodule

/* gpio_pin_slice.sv */
// one pin: input synchroniser, buffer gating, sensing and peripheral override
`timescale 1ns/1ps
module gpio_pin_slice (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [31:0] i_setup,
  input  wire logic        i_out,
  input  wire logic        i_pad_in,
  input  wire logic        i_ovr_en,
  input  wire logic        i_ovr_out,
  input  wire logic        i_ovr_dir,
  output logic             o_in,
  output logic             o_detect,
  output logic             o_pad_out,
  output logic             o_pad_oe,
  output logic [1:0]       o_pull,
  output logic [2:0]       o_drive
);
  import gpio_port_pkg::*;

  typedef struct packed {
    logic [1:0] sync;
  } slice_s;

  slice_s st_r;
  slice_s st_nxt;
  logic       connected;
  logic [1:0] sense;

  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.sync = {st_r.sync[0], i_pad_in};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign connected = ~i_setup[SETUP_INDIS_BIT];
  assign sense     = i_setup[SETUP_SENSE_LSB +: 2];
  // a disconnected buffer gives neither readback nor sensing a value
  assign o_in      = connected & st_r.sync[1];
  always_comb begin
    case (sense)
      SENSE_HIGH: o_detect = connected & st_r.sync[1];
      SENSE_LOW:  o_detect = connected & ~st_r.sync[1];
      default:    o_detect = 1'b0;
    endcase
  end
  // a peripheral that owns the pin takes over its value and direction
  assign o_pad_out = i_ovr_en ? i_ovr_out : i_out;
  assign o_pad_oe  = i_ovr_en ? i_ovr_dir : i_setup[SETUP_DIR_BIT];
  assign o_pull    = i_setup[SETUP_PULL_LSB +: 2];
  assign o_drive   = i_setup[SETUP_DRIVE_LSB +: 3];
endmodule

/* gpio_port_pkg.sv */
// package: register map, field layout and reset values of the gpio port
package gpio_port_pkg;
  localparam int NUM_PINS = 32;
  // register byte offsets
  localparam logic [11:0] OFS_OUT     = 12'h004;
  localparam logic [11:0] OFS_OUTSET  = 12'h008;
  localparam logic [11:0] OFS_OUTCLR  = 12'h00C;
  localparam logic [11:0] OFS_IN      = 12'h010;
  localparam logic [11:0] OFS_DIR     = 12'h014;
  localparam logic [11:0] OFS_DIRSET  = 12'h018;
  localparam logic [11:0] OFS_DIRCLR  = 12'h01C;
  localparam logic [11:0] OFS_LATCH   = 12'h020;
  localparam logic [11:0] OFS_NSMODE  = 12'h024;
  localparam logic [11:0] OFS_SMODE   = 12'h028;
  localparam logic [11:0] OFS_SETUP   = 12'h200;
  // per_pin_setup field layout
  localparam int SETUP_DIR_BIT   = 0;
  localparam int SETUP_INDIS_BIT = 1;
  localparam int SETUP_PULL_LSB  = 2;
  localparam int SETUP_DRIVE_LSB = 8;
  localparam int SETUP_SENSE_LSB = 16;
  localparam logic [31:0] SETUP_MASK  = 32'h0003_070F;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0002;
  localparam logic [1:0] SENSE_OFF  = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW  = 2'h3;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // cycles the pad input passes through before the input register
  localparam int SYNC_STAGES = 2;
endpackage

/* gpio_port_properties.sv */
// checker: port-level properties of the gpio port, bound to its top module
`timescale 1ns/1ps
module gpio_port_checker
  import gpio_port_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [2:0]  i_pprot,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic [31:0] i_pin_security_map,
  input wire logic [31:0] i_pad_in,
  input wire logic [31:0] o_pad_out,
  input wire logic [31:0] i_ovr_en,
  input wire logic [31:0] i_ovr_out,
  input wire logic [31:0] o_periph_in
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // read setup, then read data in the next cycle
  // ----------------------------------------
  sequence s_rd_setup;
    i_ce && i_psel && !i_penable && !i_pwrite;
  endsequence
  sequence s_ns_rd_setup;
    s_rd_setup ##0 i_pprot[1];
  endsequence
  a_pready_high: assert property (o_pready)
    else $error("pready not high");
  a_no_slverr: assert property (i_psel && i_penable |-> !o_pslverr)
    else $error("slave error raised");
  a_ovr_value: assert property ((i_ovr_en & (o_pad_out ^ i_ovr_out)) == 32'h0)
    else $error("override value not on pad");
  a_input_sync: assert property (i_ce |->
    (o_periph_in & ~$past(o_periph_in) & ~$past(i_pad_in, 2)) == 32'h0)
    else $error("input rose without pad two cycles before");
  a_in_readback: assert property (s_rd_setup ##0 (i_paddr == OFS_IN && !i_pprot[1])
    |=> o_prdata == $past(o_periph_in)) else $error("input register mismatch");
  a_ns_filter: assert property (s_ns_rd_setup ##0 (i_paddr < OFS_NSMODE)
    |=> (o_prdata & $past(i_pin_security_map)) == 32'h0) else $error("secure bit leaked");
  a_smode_hidden: assert property (s_ns_rd_setup ##0 (i_paddr == OFS_SMODE)
    |=> o_prdata == 32'h0) else $error("secure select visible");
  a_prdata_stands: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data moved outside setup");
endmodule
bind gpio_port_sense_security gpio_port_checker u_checker (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pprot(i_pprot),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_pin_security_map(i_pin_security_map), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
  .i_ovr_en(i_ovr_en), .i_ovr_out(i_ovr_out), .o_periph_in(o_periph_in)
);

/* gpio_port_sense_security.sv */
// gpio port top: apb registers, security filter, sticky flags and wake outputs
`timescale 1ns/1ps
module gpio_port_sense_security (
  input  wire logic                                 i_clock,
  input  wire logic                                 i_rst_n,
  input  wire logic                                 i_ce,
  input  wire logic                                 i_psel,
  input  wire logic                                 i_penable,
  input  wire logic                                 i_pwrite,
  input  wire logic [11:0]                          i_paddr,
  input  wire logic [31:0]                          i_pwdata,
  input  wire logic [2:0]                           i_pprot,
  output logic                                      o_pready,
  output logic [31:0]                               o_prdata,
  output logic                                      o_pslverr,
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]   i_pin_security_map,
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]   i_pad_in,
  output logic [gpio_port_pkg::NUM_PINS-1:0]        o_pad_out,
  output logic [gpio_port_pkg::NUM_PINS-1:0]        o_pad_oe,
  output logic [2*gpio_port_pkg::NUM_PINS-1:0]      o_pad_pull,
  output logic [3*gpio_port_pkg::NUM_PINS-1:0]      o_pad_drive,
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]   i_ovr_en,
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]   i_ovr_out,
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]   i_ovr_dir,
  output logic [gpio_port_pkg::NUM_PINS-1:0]        o_periph_in,
  output logic                                      o_nonsecure_port_wake,
  output logic                                      o_secure_port_wake
);
  import gpio_port_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] latch;
    logic [NUM_PINS-1:0] det_d;
    logic                ns_mode;
    logic                s_mode;
    logic                ns_clr_pulse;
    logic                s_clr_pulse;
    logic [31:0]         rdata;
  } port_s;

  port_s      st_r;
  port_s      st_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n_q;

  logic [31:0]         setup_r [NUM_PINS];
  logic [NUM_PINS-1:0] in_vec;
  logic [NUM_PINS-1:0] det_vec;
  logic [NUM_PINS-1:0] pin_dir;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // the second copy of the reset synchroniser resets everything else;
  // kept apart from the state struct since it runs on the raw reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_q = rst_sync_r[1];

  // ----------------------------------------------------------------
  // pin slices
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      gpio_pin_slice u_slice (
        .i_clock   (i_clock),
        .i_rst_n   (rst_n_q),
        .i_ce      (i_ce),
        .i_setup   (setup_r[g]),
        .i_out     (st_r.out[g]),
        .i_pad_in  (i_pad_in[g]),
        .i_ovr_en  (i_ovr_en[g]),
        .i_ovr_out (i_ovr_out[g]),
        .i_ovr_dir (i_ovr_dir[g]),
        .o_in      (in_vec[g]),
        .o_detect  (det_vec[g]),
        .o_pad_out (o_pad_out[g]),
        .o_pad_oe  (o_pad_oe[g]),
        .o_pull    (o_pad_pull[2*g +: 2]),
        .o_drive   (o_pad_drive[3*g +: 3])
      );
      assign pin_dir[g] = setup_r[g][SETUP_DIR_BIT];
    end
  endgenerate
  assign o_periph_in = in_vec;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic                is_sec;
  logic                wr_en;
  logic                rd_en;
  logic [NUM_PINS-1:0] allow;
  logic                setup_hit;
  logic [4:0]          setup_idx;
  logic                pin_allowed;
  logic [NUM_PINS-1:0] wbits;
  logic [NUM_PINS-1:0] latch_clr;
  logic [NUM_PINS-1:0] det_rise;
  logic [NUM_PINS-1:0] latch_new;

  assign is_sec      = ~i_pprot[1];
  // non-secure access only reaches bits of non-secure pins
  assign allow       = is_sec ? {NUM_PINS{1'b1}} : ~i_pin_security_map;
  assign wr_en       = i_ce & i_psel & i_penable & i_pwrite;
  assign rd_en       = i_ce & i_psel & ~i_penable & ~i_pwrite;
  assign setup_hit   = (i_paddr[11:7] == OFS_SETUP[11:7]) && (i_paddr[1:0] == 2'b00);
  assign setup_idx   = i_paddr[6:2];
  assign pin_allowed = allow[setup_idx];
  assign wbits       = i_pwdata & allow;
  // filtered accesses still finish with a normal zero-wait answer
  assign o_pready    = 1'b1;
  assign o_pslverr   = 1'b0;
  assign o_prdata    = st_r.rdata;

  // ----------------------------------------------------------------
  // per_pin_setup array
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        setup_r[k] <= SETUP_RESET;
      end
    end else if (wr_en && setup_hit && pin_allowed) begin
      setup_r[setup_idx] <= i_pwdata & SETUP_MASK;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags and wake
  // ----------------------------------------------------------------
  assign det_rise  = det_vec & ~st_r.det_d;
  assign latch_clr = (wr_en && i_paddr == OFS_LATCH) ? wbits : '0;
  // a clear is refused while the pin still detects; a new rise wins over it
  assign latch_new = (st_r.latch & ~(latch_clr & ~det_vec)) | det_rise;

  logic [NUM_PINS-1:0] ns_pins;
  logic [NUM_PINS-1:0] s_pins;
  logic                ns_sticky;
  logic                s_sticky;
  assign ns_pins   = ~i_pin_security_map;
  assign s_pins    = i_pin_security_map;
  // one cycle low after a clear leaves flags set, giving a fresh rising edge
  assign ns_sticky = |(st_r.latch & ns_pins) & ~st_r.ns_clr_pulse;
  assign s_sticky  = |(st_r.latch & s_pins) & ~st_r.s_clr_pulse;
  // combinational from the synchronised detect and latch, so a pad change needs two clocks to reach wake, three in sticky mode via the latch
  assign o_nonsecure_port_wake = st_r.ns_mode ? ns_sticky
                                              : |(det_vec & ns_pins);
  assign o_secure_port_wake    = st_r.s_mode ? s_sticky
                                             : |(det_vec & s_pins);

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic [31:0] setup_rd;

  always_comb begin
    setup_rd = pin_allowed ? setup_r[setup_idx] : WORD_RESET;
    case (i_paddr)
      OFS_OUT, OFS_OUTSET, OFS_OUTCLR: rd_word = st_r.out & allow;
      OFS_IN:                          rd_word = in_vec & allow;
      OFS_DIR, OFS_DIRSET, OFS_DIRCLR: rd_word = pin_dir & allow;
      OFS_LATCH:                       rd_word = st_r.latch & allow;
      OFS_NSMODE:                      rd_word = {31'h0000_0000, st_r.ns_mode};
      OFS_SMODE:                       rd_word = {31'h0000_0000, st_r.s_mode & is_sec};
      default:                         rd_word = setup_hit ? setup_rd : WORD_RESET;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.det_d        = det_vec;
      st_nxt.latch        = latch_new;
      st_nxt.ns_clr_pulse = 1'b0;
      st_nxt.s_clr_pulse  = 1'b0;
      if (rd_en) begin
        st_nxt.rdata = rd_word;
      end
      if (wr_en) begin
        case (i_paddr)
          OFS_OUT:    st_nxt.out = (st_r.out & ~allow) | wbits;
          OFS_OUTSET: st_nxt.out = st_r.out | wbits;
          OFS_OUTCLR: st_nxt.out = st_r.out & ~wbits;
          OFS_LATCH: begin
            st_nxt.ns_clr_pulse = |(latch_clr & ns_pins);
            st_nxt.s_clr_pulse  = |(latch_clr & s_pins);
          end
          OFS_NSMODE: st_nxt.ns_mode = i_pwdata[0];
          OFS_SMODE: begin
            if (is_sec) begin
              st_nxt.s_mode = i_pwdata[0];
            end
          end
          default: st_nxt.out = st_r.out;
        endcase
      end
    end
  end

  // direction lives only in per_pin_setup bit 0, so direction register writes are dropped
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_r.out          <= WORD_RESET;
      st_r.latch        <= WORD_RESET;
      st_r.det_d        <= WORD_RESET;
      st_r.ns_mode      <= 1'b0;
      st_r.s_mode       <= 1'b0;
      st_r.ns_clr_pulse <= 1'b0;
      st_r.s_clr_pulse  <= 1'b0;
      st_r.rdata        <= WORD_RESET;
    end else begin
      st_r.out          <= st_nxt.out;
      st_r.latch        <= st_nxt.latch;
      st_r.det_d        <= st_nxt.det_d;
      st_r.ns_mode      <= st_nxt.ns_mode;
      st_r.s_mode       <= st_nxt.s_mode;
      st_r.ns_clr_pulse <= st_nxt.ns_clr_pulse;
      st_r.s_clr_pulse  <= st_nxt.s_clr_pulse;
      st_r.rdata        <= st_nxt.rdata;
    end
  end
endmodule

/* gpio_port_sense_security_bench.sv */
// testbench: scenario tasks driving the gpio port over apb and its pads
`timescale 1ns/1ps
module gpio_port_sense_security_bench;
  import gpio_port_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1, drop_seen = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, wake_ns, wake_s;
  logic [2:0]  pprot = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, smap = 32'h0, ovr_en = 32'h0, ovr_out = 32'h0, ovr_dir = 32'h0;
  logic [31:0] ext_en = 32'h0000_0360, ext_val = 32'h0000_0040;
  logic [31:0] prdata, q, pad, pad_out, pad_oe, periph_in;
  logic [63:0] pad_pull;
  logic [95:0] pad_drive;
  int          bad_count = 0;
  int          total_checks = 0;
  always #10 clock = ~clock;
  always @(negedge wake_ns) drop_seen = 1'b1;
  gpio_port_sense_security dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pprot(pprot),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_pin_security_map(smap),
    .i_pad_in(pad), .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_pull(pad_pull),
    .o_pad_drive(pad_drive), .i_ovr_en(ovr_en), .i_ovr_out(ovr_out), .i_ovr_dir(ovr_dir),
    .o_periph_in(periph_in), .o_nonsecure_port_wake(wake_ns), .o_secure_port_wake(wake_s)
  );
  gpio_pad_model pads (
    .i_ext_en(ext_en), .i_ext_val(ext_val), .i_oe(pad_oe), .i_out(pad_out),
    .i_clock(clock), .o_pad(pad)
  );
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] b32(input logic x);
    return {31'h0, x};
  endfunction
  function automatic logic [11:0] setup_addr(input int n);
    return OFS_SETUP + 12'(4 * n);
  endfunction
  // ----------------------------------------
  // apb master: setup, access until pready, release
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ns);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clock);
      n++;
    end
    if (n == 16) begin
      bad_count++;
      final_report();
    end
    q = prdata;
    check(b32(pslverr), 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    apb(1'b0, OFS_LATCH, 32'h0, 1'b0);
    check(q, WORD_RESET);
    apb(1'b0, setup_addr(31), 32'h0, 1'b0);
    check(q, SETUP_RESET);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 1'b0);
    check(q, 32'h0);
    apb(1'b1, setup_addr(3), 32'h0000_0505, 1'b0);
    check({pad_drive[11:9], pad_pull[7:6], pad_oe[3]}, 32'h2B);
    apb(1'b1, OFS_OUTSET, 32'h0000_0008, 1'b0);
    check(b32(pad_out[3]), 32'h1);
    apb(1'b1, OFS_OUTCLR, 32'h0000_0008, 1'b0);
    check(b32(pad_out[3]), 32'h0);
    apb(1'b1, OFS_OUT, 32'h0000_0008, 1'b0);
    check(b32(pad_out[3]), 32'h1);
    apb(1'b0, OFS_DIR, 32'h0, 1'b0);
    check(q, 32'h0000_0008);
    apb(1'b1, OFS_OUT, 32'h0000_0000, 1'b0);
    check(b32(pad_out[3]), 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_input;
    apb(1'b1, setup_addr(5), 32'h0, 1'b0);
    ext_val[5] <= 1'b1;
    @(posedge clock);
    #1 check(b32(periph_in[5]), 32'h0);
    @(posedge clock);
    #1 check(b32(periph_in[5]), 32'h1);
    @(posedge clock);
    apb(1'b0, OFS_IN, 32'h0, 1'b0);
    check(q & 32'h0000_0060, 32'h0000_0020);
    ovr_en[7] <= 1'b1;
    ovr_out[7] <= 1'b1;
    ovr_dir[7] <= 1'b1;
    apb(1'b1, setup_addr(7), 32'h0, 1'b0);
    repeat (2) @(posedge clock);
    check(b32(pad_out[7] & pad_oe[7] & periph_in[7]), 32'h1);
    ovr_en[7] <= 1'b0;
    $display("test_input done");
  endtask
  task automatic test_sense;
    apb(1'b1, setup_addr(5), {14'h0, SENSE_HIGH, 16'h0}, 1'b0);
    check(b32(wake_ns), 32'h1);
    apb(1'b1, OFS_LATCH, 32'h0000_0020, 1'b0);
    apb(1'b0, OFS_LATCH, 32'h0, 1'b0);
    check(q, 32'h0000_0020);
    ext_val[5] <= 1'b0;
    repeat (3) @(posedge clock);
    check(b32(wake_ns), 32'h0);
    apb(1'b0, OFS_LATCH, 32'h0, 1'b0);
    check(q, 32'h0000_0020);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, setup_addr(5), {14'h0, 2'(m), 16'h0}, 1'b0);
      check(b32(wake_ns), b32(2'(m) == SENSE_LOW));
    end
    apb(1'b1, setup_addr(5), 32'h0002_0000, 1'b0);
    apb(1'b1, OFS_LATCH, 32'h0000_0020, 1'b0);
    apb(1'b0, OFS_LATCH, 32'h0, 1'b0);
    check(q, 32'h0);
    $display("test_sense done");
  endtask
  task automatic test_sticky;
    apb(1'b1, setup_addr(8), 32'h0002_0000, 1'b0);
    apb(1'b1, OFS_NSMODE, 32'h1, 1'b0);
    ext_val[5] <= 1'b1;
    ext_val[8] <= 1'b1;
    repeat (3) @(posedge clock);
    ext_val[5] <= 1'b0;
    ext_val[8] <= 1'b0;
    repeat (3) @(posedge clock);
    check(b32(wake_ns), 32'h1);
    apb(1'b0, OFS_LATCH, 32'h0, 1'b0);
    check(q, 32'h0000_0120);
    drop_seen = 1'b0;
    apb(1'b1, OFS_LATCH, 32'h0000_0020, 1'b0);
    @(posedge clock);
    check(b32(drop_seen & wake_ns), 32'h1);
    apb(1'b1, OFS_LATCH, 32'h0000_0100, 1'b0);
    check(b32(wake_ns), 32'h0);
    apb(1'b1, OFS_NSMODE, 32'h0, 1'b0);
    $display("test_sticky done");
  endtask
  task automatic test_secure;
    smap[9] <= 1'b1;
    apb(1'b1, OFS_OUTSET, 32'h0000_0210, 1'b1);
    apb(1'b0, OFS_OUT, 32'h0, 1'b0);
    check(q, 32'h0000_0010);
    apb(1'b1, setup_addr(9), 32'h0000_0001, 1'b1);
    apb(1'b0, setup_addr(9), 32'h0, 1'b0);
    check(q, SETUP_RESET);
    apb(1'b1, OFS_SMODE, 32'h1, 1'b0);
    apb(1'b1, OFS_SMODE, 32'h0, 1'b1);
    apb(1'b0, OFS_SMODE, 32'h0, 1'b1);
    check(q, 32'h0);
    apb(1'b0, OFS_SMODE, 32'h0, 1'b0);
    check(q, 32'h1);
    apb(1'b1, setup_addr(9), 32'h0002_0000, 1'b0);
    ext_val[9] <= 1'b1;
    repeat (4) @(posedge clock);
    check({30'h0, wake_s, wake_ns}, 32'h2);
    $display("test_secure done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_regs();
    test_input();
    test_sense();
    test_sticky();
    test_secure();
    final_report();
  end
endmodule
